/* rtl/csc_pkg.sv */
package csc_pkg;

  // ****************************************************************
  // register map (word indices decoded from haddr[7:2], one aligned word each)
  // ****************************************************************
  localparam logic [5:0] CSC_IDX_CTRL = 6'h00;
  localparam logic [5:0] CSC_IDX_CFG = 6'h01;
  localparam logic [5:0] CSC_IDX_IRQ_EN = 6'h02;
  localparam logic [5:0] CSC_IDX_FLAGS = 6'h03;
  localparam logic [5:0] CSC_IDX_FLAG_CLR = 6'h04;
  localparam logic [5:0] CSC_IDX_BACKUP = 6'h05;

  // ****************************************************************
  // clock_control_register fields
  // ****************************************************************
  localparam int CSC_CR_MSI_ON = 0;
  localparam int CSC_CR_MSI_RDY = 1;
  localparam int CSC_CR_MSI_LOCK = 2;
  localparam int CSC_CR_MSI_RANGE = 4;
  localparam int CSC_CR_INTERNAL_16M_OSC_ON = 8;
  localparam int CSC_CR_INTERNAL_16M_OSC_RDY = 9;
  localparam int CSC_CR_HSE_ON = 16;
  localparam int CSC_CR_HSE_RDY = 17;
  localparam int CSC_CR_HSE_BYP = 18;
  localparam int CSC_CR_CSS_ON = 19;
  localparam int CSC_CR_PLL_ON = 24;
  localparam int CSC_CR_PLL_RDY = 25;
  localparam int CSC_CR_INTERNAL_48M_OSC_ON = 26;
  localparam int CSC_CR_INTERNAL_48M_OSC_RDY = 27;

  // ****************************************************************
  // configuration, interrupt enable, flag and backup fields
  // ****************************************************************
  localparam int CSC_CFG_SW = 0;
  localparam int CSC_CFG_SWS = 2;
  localparam int CSC_CFG_AHB = 4;
  localparam int CSC_CFG_APB1 = 8;
  localparam int CSC_CFG_APB2 = 12;
  localparam int CSC_CFG_AHB_EFF = 16;
  localparam int CSC_IRQ_LSE = 0;
  localparam int CSC_IRQ_HSE = 1;
  localparam int CSC_IRQ_CSS = 8;
  localparam int CSC_BD_LSE_ON = 0;
  localparam int CSC_BD_LSE_RDY = 1;
  localparam int CSC_BD_LSE_BYP = 2;
  localparam int CSC_BD_LSE_DRV = 3;
  localparam int CSC_BD_RTC_SEL = 8;
  localparam int CSC_BD_LSI_ON = 15;
  localparam int CSC_BD_LSI_RDY = 16;

  // ****************************************************************
  // sources, frequencies, reset values
  // ****************************************************************
  typedef enum logic [1:0] {
    CSC_SRC_MSI,
    CSC_SRC_INTERNAL_16M_OSC,
    CSC_SRC_HSE,
    CSC_SRC_PLL
  } csc_src_type;

  localparam logic [3:0] CSC_MSI_RANGE_RST = 4'h6;
  localparam logic [3:0] CSC_MSI_RANGE_MAX = 4'hB;
  localparam logic [31:0] CSC_INTERNAL_16M_OSC_KHZ = 32'd16000;
  localparam logic [31:0] CSC_HSE_KHZ = 32'd48000;
  localparam logic [31:0] CSC_PLL_KHZ = 32'd110000;
  localparam logic [31:0] CSC_BUS_MAX_KHZ = 32'd110000;
  localparam logic [2:0] CSC_PRE_MAX = 3'h7;
  localparam logic [1:0] CSC_RTC_NONE = 2'h0;

  function automatic logic [31:0] csc_msi_khz(input logic [3:0] range);
    logic [31:0] f;
    f = 32'd4000;
    unique case (range)
      4'h0: f = 32'd100;
      4'h1: f = 32'd200;
      4'h2: f = 32'd400;
      4'h3: f = 32'd800;
      4'h4: f = 32'd1000;
      4'h5: f = 32'd2000;
      4'h6: f = 32'd4000;
      4'h7: f = 32'd8000;
      4'h8: f = 32'd16000;
      4'h9: f = 32'd24000;
      4'hA: f = 32'd32000;
      4'hB: f = 32'd48000;
      default: f = 32'd4000;
    endcase
    return f;
  endfunction

  // ****************************************************************
  // complete state of the block
  // ****************************************************************
  typedef struct packed {
    logic pend;
    logic pwrite;
    logic [5:0] pidx;
    logic hready;
    logic [31:0] hrdata;
    logic msi_on;
    logic msi_rdy;
    logic msi_lock;
    logic msi_trim;
    logic [3:0] msi_range;
    logic internal_16m_osc_on;
    logic internal_16m_osc_rdy;
    logic hse_on;
    logic hse_rdy;
    logic hse_byp;
    logic css_on;
    logic pll_on;
    logic pll_rdy;
    logic internal_48m_osc_on;
    logic internal_48m_osc_rdy;
    csc_src_type sw;
    csc_src_type sws;
    logic [2:0] ahb_pre;
    logic [2:0] apb1_pre;
    logic [2:0] apb2_pre;
    logic [2:0] ahb_eff;
    logic lse_ie;
    logic hse_ie;
    logic lse_f;
    logic hse_f;
    logic css_f;
    logic lse_on;
    logic lse_rdy;
    logic lse_byp;
    logic [1:0] lse_drv;
    logic [1:0] rtc_sel;
    logic lsi_on;
    logic lsi_rdy;
    logic irq;
  } csc_state_type;

  localparam csc_state_type CSC_STATE_RST = '{
    pend: 1'b0, pwrite: 1'b0, pidx: 6'h00, hready: 1'b1, hrdata: 32'h0000_0000,
    msi_on: 1'b1, msi_rdy: 1'b0, msi_lock: 1'b0, msi_trim: 1'b0,
    msi_range: CSC_MSI_RANGE_RST,
    internal_16m_osc_on: 1'b0, internal_16m_osc_rdy: 1'b0, hse_on: 1'b0, hse_rdy: 1'b0, hse_byp: 1'b0,
    css_on: 1'b0, pll_on: 1'b0, pll_rdy: 1'b0, internal_48m_osc_on: 1'b0, internal_48m_osc_rdy: 1'b0,
    sw: CSC_SRC_MSI, sws: CSC_SRC_MSI,
    ahb_pre: 3'h0, apb1_pre: 3'h0, apb2_pre: 3'h0, ahb_eff: 3'h0,
    lse_ie: 1'b0, hse_ie: 1'b0, lse_f: 1'b0, hse_f: 1'b0, css_f: 1'b0,
    lse_on: 1'b0, lse_rdy: 1'b0, lse_byp: 1'b0, lse_drv: 2'h0,
    rtc_sel: CSC_RTC_NONE, lsi_on: 1'b0, lsi_rdy: 1'b0, irq: 1'b0
  };

endpackage

/* rtl/csc_clock_source_control.sv */
`timescale 1ns/1ns

// Summary of operation
// - system clock comes from msi, 16 MHz internal, high-speed external or pll.
// - after reset the system clock runs from msi at 4 MHz.
// - each oscillator has its own on/off bit.
// - ahb and apb prescalers; no bus domain may exceed 110 MHz.
// - hs external ready flag set when stable; its clock withheld until then.
// - hs or ls external becoming ready raises interrupt when enabled.
// - hs external oscillator follows its enable bit.
// - bypass needs both bypass and enable bits; external clock at most 48 MHz.
// - in hs bypass the oscillator output pin is left free for gpio.
// - 4-bit range field selects twelve msi frequencies, default 4 MHz.
// - lock mode bit makes msi trim itself against the 32.768 kHz crystal.
// - ls crystal oscillator follows its enable bit in the backup register.
// - 2-bit ls drive field is changeable at run time.
// - while ls enabled the drive may drop but never rise.
// - ls ready flag set when stable; ls clock withheld until then.
// - ls bypass needs bypass and enable; output pin freed for gpio.
// - low-speed internal feeds watchdog; rtc from it or from ls crystal.
// - 48 MHz internal oscillator routable to usb, sd card and rng.
// - 16 MHz internal backs up a failed hs crystal under security system.
module csc_clock_source_control
  import csc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic msi_stable,
  input wire logic internal_16m_osc_stable,
  input wire logic hse_stable,
  input wire logic hse_fail,
  input wire logic pll_locked,
  input wire logic internal_48m_osc_stable,
  input wire logic lse_stable,
  input wire logic lsi_stable,
  output logic msi_enable,
  output logic [3:0] msi_range,
  output logic msi_trim_enable,
  output logic internal_16m_osc_enable,
  output logic hse_enable,
  output logic hse_bypass,
  output logic pll_enable,
  output logic internal_48m_osc_enable,
  output logic internal_48m_osc_route_enable,
  output logic lse_enable,
  output logic lse_bypass,
  output logic [1:0] lse_drive,
  output logic lsi_enable,
  output logic lsi_watchdog_enable,
  output logic [1:0] rtc_source,
  output logic hse_clock_release,
  output logic lse_clock_release,
  output logic [1:0] system_clock_source,
  output logic [2:0] ahb_div_shift,
  output logic [2:0] apb1_div_shift,
  output logic [2:0] apb2_div_shift,
  output logic clock_irq
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] src_khz(input csc_src_type s, input logic [3:0] r);
    logic [31:0] f;
    f = csc_msi_khz(r);
    unique case (s)
      CSC_SRC_MSI: f = csc_msi_khz(r);
      CSC_SRC_INTERNAL_16M_OSC: f = CSC_INTERNAL_16M_OSC_KHZ;
      CSC_SRC_HSE: f = CSC_HSE_KHZ;
      CSC_SRC_PLL: f = CSC_PLL_KHZ;
    endcase
    return f;
  endfunction

  // smallest ahb shift keeping the bus at or under its ceiling
  function automatic logic [2:0] min_shift(input logic [31:0] khz);
    logic [2:0] s;
    s = CSC_PRE_MAX;
    for (int i = 7; i >= 0; i--) begin
      if ((khz >> i) <= CSC_BUS_MAX_KHZ) begin
        s = 3'(i);
      end
    end
    return s;
  endfunction

  csc_state_type q;
  csc_state_type d;
  logic [31:0] rd_word;
  logic accept;
  logic src_ready;
  logic [2:0] need_shift;
  logic [1:0] new_drv;

  // ****************************************************************
  // register read view
  // ****************************************************************
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (q.pidx)
      CSC_IDX_CTRL: begin
        rd_word[CSC_CR_MSI_ON] = q.msi_on;
        rd_word[CSC_CR_MSI_RDY] = q.msi_rdy;
        rd_word[CSC_CR_MSI_LOCK] = q.msi_lock;
        rd_word[CSC_CR_MSI_RANGE +: 4] = q.msi_range;
        rd_word[CSC_CR_INTERNAL_16M_OSC_ON] = q.internal_16m_osc_on;
        rd_word[CSC_CR_INTERNAL_16M_OSC_RDY] = q.internal_16m_osc_rdy;
        rd_word[CSC_CR_HSE_ON] = q.hse_on;
        rd_word[CSC_CR_HSE_RDY] = q.hse_rdy;
        rd_word[CSC_CR_HSE_BYP] = q.hse_byp;
        rd_word[CSC_CR_CSS_ON] = q.css_on;
        rd_word[CSC_CR_PLL_ON] = q.pll_on;
        rd_word[CSC_CR_PLL_RDY] = q.pll_rdy;
        rd_word[CSC_CR_INTERNAL_48M_OSC_ON] = q.internal_48m_osc_on;
        rd_word[CSC_CR_INTERNAL_48M_OSC_RDY] = q.internal_48m_osc_rdy;
      end
      CSC_IDX_CFG: begin
        rd_word[CSC_CFG_SW +: 2] = q.sw;
        rd_word[CSC_CFG_SWS +: 2] = q.sws;
        rd_word[CSC_CFG_AHB +: 3] = q.ahb_pre;
        rd_word[CSC_CFG_APB1 +: 3] = q.apb1_pre;
        rd_word[CSC_CFG_APB2 +: 3] = q.apb2_pre;
        rd_word[CSC_CFG_AHB_EFF +: 3] = q.ahb_eff;
      end
      CSC_IDX_IRQ_EN: begin
        rd_word[CSC_IRQ_LSE] = q.lse_ie;
        rd_word[CSC_IRQ_HSE] = q.hse_ie;
      end
      CSC_IDX_FLAGS: begin
        rd_word[CSC_IRQ_LSE] = q.lse_f;
        rd_word[CSC_IRQ_HSE] = q.hse_f;
        rd_word[CSC_IRQ_CSS] = q.css_f;
      end
      CSC_IDX_BACKUP: begin
        rd_word[CSC_BD_LSE_ON] = q.lse_on;
        rd_word[CSC_BD_LSE_RDY] = q.lse_rdy;
        rd_word[CSC_BD_LSE_BYP] = q.lse_byp;
        rd_word[CSC_BD_LSE_DRV +: 2] = q.lse_drv;
        rd_word[CSC_BD_RTC_SEL +: 2] = q.rtc_sel;
        rd_word[CSC_BD_LSI_ON] = q.lsi_on;
        rd_word[CSC_BD_LSI_RDY] = q.lsi_rdy;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    d = q;
    accept = hsel && htrans[1] && hready;
    src_ready = 1'b0;
    new_drv = hwdata[CSC_BD_LSE_DRV +: 2];
    // one wait state so that hrdata comes straight from a flop
    d.hready = 1'b1;
    d.pend = 1'b0;
    if (accept) begin
      d.pend = 1'b1;
      d.pwrite = hwrite;
      d.pidx = haddr[7:2];
      d.hready = 1'b0;
    end
    if (q.pend) begin
      d.hrdata = q.pwrite ? 32'h0000_0000 : rd_word;
    end
    if (q.pend && q.pwrite) begin
      unique case (q.pidx)
        CSC_IDX_CTRL: begin
          d.msi_on = hwdata[CSC_CR_MSI_ON];
          d.msi_lock = hwdata[CSC_CR_MSI_LOCK];
          // codes above the twelfth range are dropped, the old range stays
          if (hwdata[CSC_CR_MSI_RANGE +: 4] <= CSC_MSI_RANGE_MAX) begin
            d.msi_range = hwdata[CSC_CR_MSI_RANGE +: 4];
          end
          d.internal_16m_osc_on = hwdata[CSC_CR_INTERNAL_16M_OSC_ON];
          d.hse_on = hwdata[CSC_CR_HSE_ON];
          // bypass only changes while the oscillator is off
          if (!q.hse_on) begin
            d.hse_byp = hwdata[CSC_CR_HSE_BYP];
          end
          d.css_on = hwdata[CSC_CR_CSS_ON];
          d.pll_on = hwdata[CSC_CR_PLL_ON];
          d.internal_48m_osc_on = hwdata[CSC_CR_INTERNAL_48M_OSC_ON];
        end
        CSC_IDX_CFG: begin
          d.sw = csc_src_type'(hwdata[CSC_CFG_SW +: 2]);
          d.ahb_pre = hwdata[CSC_CFG_AHB +: 3];
          d.apb1_pre = hwdata[CSC_CFG_APB1 +: 3];
          d.apb2_pre = hwdata[CSC_CFG_APB2 +: 3];
        end
        CSC_IDX_IRQ_EN: begin
          d.lse_ie = hwdata[CSC_IRQ_LSE];
          d.hse_ie = hwdata[CSC_IRQ_HSE];
        end
        CSC_IDX_FLAG_CLR: begin
          d.lse_f = q.lse_f && !hwdata[CSC_IRQ_LSE];
          d.hse_f = q.hse_f && !hwdata[CSC_IRQ_HSE];
          d.css_f = q.css_f && !hwdata[CSC_IRQ_CSS];
        end
        CSC_IDX_BACKUP: begin
          d.lse_on = hwdata[CSC_BD_LSE_ON];
          if (!q.lse_on) begin
            d.lse_byp = hwdata[CSC_BD_LSE_BYP];
          end
          // a running crystal may be eased off but never pushed harder
          if (!q.lse_on || new_drv <= q.lse_drv) begin
            d.lse_drv = new_drv;
          end
          d.rtc_sel = hwdata[CSC_BD_RTC_SEL +: 2];
          d.lsi_on = hwdata[CSC_BD_LSI_ON];
        end
        default: d.pidx = q.pidx;
      endcase
    end

    // ready flags follow enable and the analog stable indication
    d.msi_rdy = q.msi_on && msi_stable;
    d.internal_16m_osc_rdy = q.internal_16m_osc_on && internal_16m_osc_stable;
    d.hse_rdy = q.hse_on && hse_stable;
    d.pll_rdy = q.pll_on && pll_locked;
    d.internal_48m_osc_rdy = q.internal_48m_osc_on && internal_48m_osc_stable;
    d.lse_rdy = q.lse_on && lse_stable;
    d.lsi_rdy = q.lsi_on && lsi_stable;
    // trimming only makes sense once the crystal reference is running
    d.msi_trim = q.msi_lock && q.lse_rdy;

    // rising ready edges are sticky; set wins over a same-cycle clear
    if (d.hse_rdy && !q.hse_rdy) begin
      d.hse_f = 1'b1;
    end
    if (d.lse_rdy && !q.lse_rdy) begin
      d.lse_f = 1'b1;
    end

    // failed crystal: drop it, bring up the internal 16 MHz, move off it
    if (q.css_on && q.hse_rdy && hse_fail) begin
      d.css_f = 1'b1;
      d.hse_on = 1'b0;
      d.internal_16m_osc_on = 1'b1;
      if (q.sws == CSC_SRC_HSE || q.sw == CSC_SRC_HSE) begin
        d.sw = CSC_SRC_INTERNAL_16M_OSC;
      end
    end

    // the live source cannot be stopped from under the core, except hse while css_f is set
    unique case (q.sws)
      CSC_SRC_MSI: d.msi_on = 1'b1;
      CSC_SRC_INTERNAL_16M_OSC: d.internal_16m_osc_on = 1'b1;
      CSC_SRC_HSE: d.hse_on = d.hse_on || !d.css_f;
      CSC_SRC_PLL: d.pll_on = 1'b1;
    endcase

    unique case (q.sw)
      CSC_SRC_MSI: src_ready = q.msi_rdy;
      CSC_SRC_INTERNAL_16M_OSC: src_ready = q.internal_16m_osc_rdy;
      CSC_SRC_HSE: src_ready = q.hse_rdy;
      CSC_SRC_PLL: src_ready = q.pll_rdy;
    endcase
    if (q.sw != q.sws && src_ready) begin
      d.sws = q.sw;
    end

    // ahb never faster than the ceiling; apb only divides ahb further
    need_shift = min_shift(src_khz(d.sws, d.msi_range));
    d.ahb_eff = (d.ahb_pre > need_shift) ? d.ahb_pre : need_shift;

    d.irq = (d.hse_f && d.hse_ie) || (d.lse_f && d.lse_ie) || d.css_f;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= CSC_STATE_RST;
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign hreadyout = q.hready;
  assign hrdata = q.hrdata;
  assign hresp = q.pend && 1'b0;
  assign msi_enable = q.msi_on;
  assign msi_range = q.msi_range;
  assign msi_trim_enable = q.msi_trim;
  assign internal_16m_osc_enable = q.internal_16m_osc_on;
  assign hse_enable = q.hse_on;
  assign hse_bypass = q.hse_byp;
  assign pll_enable = q.pll_on;
  assign internal_48m_osc_enable = q.internal_48m_osc_on;
  assign internal_48m_osc_route_enable = q.internal_48m_osc_rdy;
  assign lse_enable = q.lse_on;
  assign lse_bypass = q.lse_byp;
  assign lse_drive = q.lse_drv;
  assign lsi_enable = q.lsi_on;
  assign lsi_watchdog_enable = q.lsi_rdy;
  assign rtc_source = q.rtc_sel;
  assign hse_clock_release = q.hse_rdy;
  assign lse_clock_release = q.lse_rdy;
  assign system_clock_source = q.sws;
  assign ahb_div_shift = q.ahb_eff;
  assign apb1_div_shift = q.apb1_pre;
  assign apb2_div_shift = q.apb2_pre;
  assign clock_irq = q.irq;

endmodule

/* sim/csc_checker_sva.sv */
`timescale 1ns/1ns

module csc_checker
  import csc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic msi_enable,
  input wire logic [3:0] msi_range,
  input wire logic msi_trim_enable,
  input wire logic hse_stable,
  input wire logic hse_enable,
  input wire logic hse_bypass,
  input wire logic hse_clock_release,
  input wire logic internal_48m_osc_stable,
  input wire logic internal_48m_osc_enable,
  input wire logic internal_48m_osc_route_enable,
  input wire logic lse_stable,
  input wire logic lse_enable,
  input wire logic lse_bypass,
  input wire logic [1:0] lse_drive,
  input wire logic lse_clock_release,
  input wire logic [1:0] system_clock_source
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // ****************************************************************
  // bus handshake and oscillator gating
  // ****************************************************************
  bus_wait_a: assert property (hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout)
    else $error("wait state not exactly one cycle");
  reset_state_a: assert property ($fell(rst) |-> system_clock_source == 2'h0 && msi_range == 4'h6 && msi_enable)
    else $error("wrong state after reset");
  hse_release_a: assert property (hse_clock_release == ($past(hse_enable) && $past(hse_stable)))
    else $error("hs external release not tied to stable");
  lse_release_a: assert property (lse_clock_release == ($past(lse_enable) && $past(lse_stable)))
    else $error("ls external release not tied to stable");
  route48_a: assert property (internal_48m_osc_route_enable == ($past(internal_48m_osc_enable) && $past(internal_48m_osc_stable)))
    else $error("48 MHz route not tied to stable");
  range_legal_a: assert property (msi_range <= CSC_MSI_RANGE_MAX)
    else $error("multispeed range out of table");
  trim_lse_a: assert property (msi_trim_enable |-> $past(lse_clock_release))
    else $error("trim without ls crystal ready");
  drive_no_rise_a: assert property ($past(lse_enable) && lse_enable |-> lse_drive <= $past(lse_drive))
    else $error("ls drive raised while enabled");
  hse_byp_hold_a: assert property ($past(hse_enable) |-> $stable(hse_bypass))
    else $error("hs bypass changed while enabled");
  lse_byp_hold_a: assert property ($past(lse_enable) |-> $stable(lse_bypass))
    else $error("ls bypass changed while enabled");
  switch_ready_a: assert property ($changed(system_clock_source) && system_clock_source == 2'h2
    |-> $past(hse_clock_release))
    else $error("switched to hs external before ready");
endmodule

bind csc_clock_source_control csc_checker u_csc_checker (
  .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .htrans(htrans), .hready(hready), .hreadyout(hreadyout),
  .msi_enable(msi_enable), .msi_range(msi_range), .msi_trim_enable(msi_trim_enable), .hse_stable(hse_stable),
  .hse_enable(hse_enable), .hse_bypass(hse_bypass), .hse_clock_release(hse_clock_release),
  .internal_48m_osc_stable(internal_48m_osc_stable), .internal_48m_osc_enable(internal_48m_osc_enable), .internal_48m_osc_route_enable(internal_48m_osc_route_enable),
  .lse_stable(lse_stable), .lse_enable(lse_enable), .lse_bypass(lse_bypass), .lse_drive(lse_drive),
  .lse_clock_release(lse_clock_release), .system_clock_source(system_clock_source));

/* sim/csc_osc_model.sv */
`timescale 1ns/1ns

module csc_osc_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [6:0] osc_en,
  input wire logic hse_byp,
  input wire logic lse_byp,
  input wire logic slow,
  input wire logic fail_cmd,
  output logic [6:0] osc_stable,
  output logic hse_fail
);
  // ****************************************************************
  // start-up of each source: msi, internal_16m_osc, hse, pll, internal_48m_osc, lse, lsi
  // ****************************************************************
  logic [5:0] cnt [7];

  // a bypassed source settles after 4 counts; a crystal needs 6, or 40 when slow
  function automatic logic [5:0] settle(input int i);
    if ((i == 2 && hse_byp) || (i == 5 && lse_byp)) begin
      return 6'h04;
    end
    return slow ? 6'h28 : 6'h06;
  endfunction

  always @(posedge clk_sys or posedge rst) begin
    for (int i = 0; i < 7; i++) begin
      if (rst || !osc_en[i]) begin
        cnt[i] <= 6'h00;
        osc_stable[i] <= 1'b0;
      end else if (i == 2 && fail_cmd) begin
        osc_stable[i] <= 1'b0;
      end else if (cnt[i] == settle(i)) begin
        osc_stable[i] <= 1'b1;
      end else begin
        cnt[i] <= cnt[i] + 6'h01;
      end
    end
  end

  assign hse_fail = fail_cmd;
endmodule

/* sim/tb.sv */
`timescale 1ns/1ns

`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
`define WAITFOR(c) begin for (int j = 0; j < 200 && !(c); j++) @(posedge clk_sys); \
  if (!(c)) begin fails++; $display("[FAIL] t=%0t wait got=%h exp=%h", $time, 1'b0, 1'b1); end end

module tb
  import csc_pkg::*;
;
  logic clk_sys, rst, hsel, hwrite, hreadyout, hresp, hse_fail, clock_irq, slow, fail_cmd;
  logic [31:0] haddr, hwdata, hrdata, rs, r;
  logic [1:0] htrans, lse_drive, rtc_source, system_clock_source, ed;
  logic [2:0] hsize, ahb_div_shift, apb1_div_shift, apb2_div_shift;
  logic [3:0] msi_range, code, er;
  logic msi_trim_enable, hse_bypass, internal_48m_osc_route_enable, lse_bypass;
  logic lsi_watchdog_enable, hse_clock_release, lse_clock_release;
  logic [1:0] dv [4] = '{2'h1, 2'h2, 2'h0, 2'h3};
  wire [6:0] en, st;
  int fails, cmp_count;

  csc_clock_source_control u_csc_clock_source_control (
    .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .msi_stable(st[0]), .internal_16m_osc_stable(st[1]), .hse_stable(st[2]), .hse_fail(hse_fail), .pll_locked(st[3]),
    .internal_48m_osc_stable(st[4]), .lse_stable(st[5]), .lsi_stable(st[6]), .msi_enable(en[0]), .msi_range(msi_range),
    .msi_trim_enable(msi_trim_enable), .internal_16m_osc_enable(en[1]), .hse_enable(en[2]), .hse_bypass(hse_bypass),
    .pll_enable(en[3]), .internal_48m_osc_enable(en[4]), .internal_48m_osc_route_enable(internal_48m_osc_route_enable), .lse_enable(en[5]),
    .lse_bypass(lse_bypass), .lse_drive(lse_drive), .lsi_enable(en[6]), .lsi_watchdog_enable(lsi_watchdog_enable),
    .rtc_source(rtc_source), .hse_clock_release(hse_clock_release), .lse_clock_release(lse_clock_release),
    .system_clock_source(system_clock_source), .ahb_div_shift(ahb_div_shift), .apb1_div_shift(apb1_div_shift),
    .apb2_div_shift(apb2_div_shift), .clock_irq(clock_irq));

  csc_osc_model u_csc_osc_model (.clk_sys(clk_sys), .rst(rst), .osc_en(en), .hse_byp(hse_bypass),
    .lse_byp(lse_bypass), .slow(slow), .fail_cmd(fail_cmd), .osc_stable(st), .hse_fail(hse_fail));

  // ****************************************************************
  // bus master and helpers
  // ****************************************************************
  always #2 clk_sys = ~clk_sys;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic xfer(input logic [5:0] idx, input logic w, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    q = hrdata;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    logic [31:0] q;
    xfer(idx, 1'b1, d, q);
  endtask

  task automatic rd_chk(input logic [5:0] idx, input logic [31:0] e);
    logic [31:0] q;
    xfer(idx, 1'b0, 32'h0000_0000, q);
    `CHK(q, e)
  endtask

  task automatic tally_and_finish();
    if (fails == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    tally_and_finish();
  end

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    clk_sys = 1'b0; rst = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; slow = 1'b0; fail_cmd = 1'b0; fails = 0; cmp_count = 0; rs = 32'h278A;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    `CHK({system_clock_source, msi_range}, 6'h06)
    `WAITFOR(st[0])
    rd_chk(CSC_IDX_CTRL, 32'h0000_0063);
    rd_chk(CSC_IDX_CFG, 32'h0000_0000);
    rd_chk(6'h06, 32'h0000_0000);
    `CHK(hresp, 1'b0)
    wr(CSC_IDX_IRQ_EN, 32'h0000_0003);
    wr(CSC_IDX_CTRL, 32'h0005_0061);
    `CHK({en[2], hse_bypass, hse_clock_release}, 3'h6)
    `WAITFOR(hse_clock_release)
    `CHK(clock_irq, 1'b1)
    rd_chk(CSC_IDX_FLAGS, 32'h0000_0002);
    wr(CSC_IDX_FLAG_CLR, 32'h0000_0002);
    `CHK(clock_irq, 1'b0)
    wr(CSC_IDX_CTRL, 32'h0001_0061);
    `CHK(hse_bypass, 1'b1)
    wr(CSC_IDX_CFG, 32'h0000_0002);
    `WAITFOR(system_clock_source == 2'h2)
    wr(CSC_IDX_CTRL, 32'h0008_0061);
    `CHK({system_clock_source, en[2]}, 3'h5)
    fail_cmd <= 1'b1;
    `WAITFOR(system_clock_source == 2'h1)
    `CHK({en[2], en[1], clock_irq}, 3'h3)
    fail_cmd <= 1'b0;
    rd_chk(CSC_IDX_FLAGS, 32'h0000_0100);
    wr(CSC_IDX_FLAG_CLR, 32'h0000_0100);
    wr(CSC_IDX_CTRL, 32'h0500_0161);
    `CHK(en[4:0], 5'h1B)
    `WAITFOR(internal_48m_osc_route_enable)
    `CHK(internal_48m_osc_route_enable, 1'b1)
    wr(CSC_IDX_CFG, 32'h0000_0003);
    `WAITFOR(system_clock_source == 2'h3)
    wr(CSC_IDX_CTRL, 32'h0100_0061);
    `CHK({system_clock_source, en[4:0]}, 7'h69)
    wr(CSC_IDX_CFG, 32'h0000_0000);
    `WAITFOR(system_clock_source == 2'h0)
    er = 4'h6;
    rs = xs(rs);
    for (int i = 0; i < 16; i++) begin
      code = 4'(i) ^ rs[3:0];
      if (code <= CSC_MSI_RANGE_MAX) er = code;
      wr(CSC_IDX_CTRL, {24'h00_0000, code, 4'h1});
      `CHK(msi_range, er)
    end
    for (int i = 0; i < 4; i++) begin
      rs = xs(rs);
      r = rs;
      wr(CSC_IDX_CFG, {17'h0, r[8:6], 1'b0, r[5:3], 1'b0, r[2:0], 4'h0});
      `CHK({ahb_div_shift, apb1_div_shift, apb2_div_shift}, {r[2:0], r[5:3], r[8:6]})
      rd_chk(CSC_IDX_CFG, {13'h0, r[2:0], 1'b0, r[8:6], 1'b0, r[5:3], 1'b0, r[2:0], 4'h0});
    end
    slow <= 1'b1;
    wr(CSC_IDX_BACKUP, 32'h0000_8219);
    `CHK({en[6], en[5], lse_drive, rtc_source}, 6'h3E)
    `WAITFOR(lse_clock_release)
    `CHK(clock_irq, 1'b1)
    ed = 2'h3;
    for (int i = 0; i < 4; i++) begin
      if (dv[i] <= ed) ed = dv[i];
      wr(CSC_IDX_BACKUP, {24'h00_0082, 3'h0, dv[i], 3'h1});
      `CHK(lse_drive, ed)
    end
    wr(CSC_IDX_BACKUP, 32'h0000_8205);
    `CHK({en[5], lse_bypass}, 2'h2)
    wr(CSC_IDX_BACKUP, 32'h0000_8200);
    `CHK(en[5], 1'b0)
    wr(CSC_IDX_BACKUP, 32'h0000_8205);
    `CHK({en[5], lse_bypass}, 2'h3)
    wr(CSC_IDX_CTRL, {24'h00_0000, er, 4'h5});
    `WAITFOR(msi_trim_enable)
    `CHK({msi_trim_enable, lsi_watchdog_enable}, 2'h3)
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    `CHK({system_clock_source, msi_range, en[2]}, 7'h0C)
    tally_and_finish();
  end
endmodule
